//--- rtl/uwpc_phy_if.sv
// PHY end of the MAC-PHY control and data signal layer
`timescale 1ns/100ps
`default_nettype none

module uwpc_phy_if #(
   parameter int RESET_CYC = uwpc_pkg::RESET_DONE_CYC
) (
   input  wire logic       CLK_IN,             // PHY core clock, 100 MHz
   input  wire logic       NRST_IN,            // link reset from MAC, active low
   input  wire logic       LINK_CLK_IN,        // interface clock source, 66 MHz
   output logic            PCLK_OUT,           // gated interface clock to MAC
   input  wire logic       TX_REQ_IN,          // transmit request from MAC
   input  wire logic       RX_REQ_IN,          // receive request from MAC
   input  wire logic       CLOCK_STOP_REQ_IN,  // clock-stop request, async
   output logic            AIR_ACTIVITY_OUT,   // frame on air
   output logic            BYTE_STROBE_OUT,    // byte pull or byte valid
   input  wire logic [7:0] DATA_IN,            // data bus as seen at pin
   output logic      [7:0] DATA_OUT,           // data driven by PHY
   output logic            DATA_OE_N_OUT,      // low while PHY drives bus
   output logic      [4:0] POWER_MODE_OUT,     // power mode field, link domain
   output logic            RADIO_ON_OUT,       // radio path enabled
   input  wire logic       SLEEP_REQ_IN,       // core asks for sleep
   input  wire logic       ANTENNA_FRAME_IN,   // core sees frame at antenna
   input  wire logic       TX_PULL_IN,         // core wants next tx byte
   output logic            TX_PULL_READY_OUT,  // a pull may be issued
   output logic      [7:0] TX_BYTE_OUT,        // byte taken from MAC
   output logic            TX_BYTE_VALID_OUT,  // tx byte pulse
   input  wire logic [7:0] RX_BYTE_IN,         // received byte from core
   input  wire logic       RX_BYTE_VALID_IN,   // rx byte offered
   output logic            RX_BYTE_READY_OUT   // rx byte may be offered
);

   if (RESET_CYC < 1 || RESET_CYC >= (1 << uwpc_pkg::RST_CNT_W)) begin : g_reset_cyc_check
      $error("RESET_CYC out of range");
   end

   ////////////////////////////////////////////////////////////////////////////
   // link reset: asserts at once, releases on the link clock
   logic lrst_m_r;
   logic lrst_q_r;
   logic link_rst_n;
   always_ff @(posedge LINK_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         lrst_m_r <= 1'b0;
         lrst_q_r <= 1'b0;
      end else begin
         lrst_m_r <= 1'b1;
         lrst_q_r <= lrst_m_r;
      end
   end

   assign link_rst_n = lrst_q_r;

   ////////////////////////////////////////////////////////////////////////////
   // core domain: levels launched from flops, handshakes for bytes
   logic       sleep_c_r, frame_c_r;
   logic       tx_req_tgl_r, tx_ack_m_r, tx_ack_q_r, tx_ack_d_r, tx_ack_tgl_r, tx_ok_r;
   logic       rx_req_tgl_r, rx_ack_m_r, rx_ack_q_r, rx_ack_tgl_r;
   logic [7:0] rx_hold_r, tx_byte_r;

   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         sleep_c_r <= 1'b0;
         frame_c_r <= 1'b0;
      end else begin
         sleep_c_r <= SLEEP_REQ_IN;
         frame_c_r <= ANTENNA_FRAME_IN;
      end
   end

   assign TX_PULL_READY_OUT = (tx_req_tgl_r == tx_ack_d_r);
   assign RX_BYTE_READY_OUT = (rx_req_tgl_r == rx_ack_q_r);

   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         tx_req_tgl_r      <= 1'b0;
         tx_ack_m_r        <= 1'b0;
         tx_ack_q_r        <= 1'b0;
         tx_ack_d_r        <= 1'b0;
         TX_BYTE_OUT       <= uwpc_pkg::DATA_RESET;
         TX_BYTE_VALID_OUT <= 1'b0;
      end else begin
         tx_ack_m_r        <= tx_ack_tgl_r;
         tx_ack_q_r        <= tx_ack_m_r;
         tx_ack_d_r        <= tx_ack_q_r;
         TX_BYTE_VALID_OUT <= (tx_ack_q_r != tx_ack_d_r) && tx_ok_r;
         if (tx_ack_q_r != tx_ack_d_r) begin
            TX_BYTE_OUT <= tx_byte_r;
         end
         if (TX_PULL_IN && TX_PULL_READY_OUT) begin
            tx_req_tgl_r <= ~tx_req_tgl_r;
         end
      end
   end

   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         rx_req_tgl_r <= 1'b0;
         rx_hold_r    <= uwpc_pkg::DATA_RESET;
         rx_ack_m_r   <= 1'b0;
         rx_ack_q_r   <= 1'b0;
      end else begin
         rx_ack_m_r <= rx_ack_tgl_r;
         rx_ack_q_r <= rx_ack_m_r;
         if (RX_BYTE_VALID_IN && RX_BYTE_READY_OUT) begin
            rx_hold_r    <= RX_BYTE_IN;
            rx_req_tgl_r <= ~rx_req_tgl_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // link domain synchronisers
   logic sleep_m_r, sleep_q_r;
   logic frame_m_r, frame_q_r;
   logic stop_m_r,  stop_q_r;
   logic wtx_m_r,   wtx_q_r;
   logic wrx_m_r,   wrx_q_r;
   logic txr_m_r,   txr_q_r,   txr_d_r;
   logic rxr_m_r,   rxr_q_r,   rxr_d_r;
   logic tx_edge;
   logic rx_edge;
   always_ff @(posedge LINK_CLK_IN or negedge link_rst_n) begin
      if (!link_rst_n) begin
         sleep_m_r <= 1'b0;
         sleep_q_r <= 1'b0;
         frame_m_r <= 1'b0;
         frame_q_r <= 1'b0;
         stop_m_r  <= 1'b0;
         stop_q_r  <= 1'b0;
         wtx_m_r   <= 1'b0;
         wtx_q_r   <= 1'b0;
         wrx_m_r   <= 1'b0;
         wrx_q_r   <= 1'b0;
         txr_m_r   <= 1'b0;
         txr_q_r   <= 1'b0;
         txr_d_r   <= 1'b0;
         rxr_m_r   <= 1'b0;
         rxr_q_r   <= 1'b0;
         rxr_d_r   <= 1'b0;
      end else begin
         sleep_m_r <= sleep_c_r;
         sleep_q_r <= sleep_m_r;
         frame_m_r <= frame_c_r;
         frame_q_r <= frame_m_r;
         stop_m_r  <= CLOCK_STOP_REQ_IN;
         stop_q_r  <= stop_m_r;
         wtx_m_r   <= TX_REQ_IN;
         wtx_q_r   <= wtx_m_r;
         wrx_m_r   <= RX_REQ_IN;
         wrx_q_r   <= wrx_m_r;
         txr_m_r   <= tx_req_tgl_r;
         txr_q_r   <= txr_m_r;
         txr_d_r   <= txr_q_r;
         rxr_m_r   <= rx_req_tgl_r;
         rxr_q_r   <= rxr_m_r;
         rxr_d_r   <= rxr_q_r;
      end
   end

   assign tx_edge = txr_q_r ^ txr_d_r;
   assign rx_edge = rxr_q_r ^ rxr_d_r;

   ////////////////////////////////////////////////////////////////////////////
   // operating state

   uwpc_pkg::uwpc_state_t                st_r;
   uwpc_pkg::uwpc_state_t                st_nxt;
   logic [uwpc_pkg::RST_CNT_W-1:0]       rst_cnt_r;

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         uwpc_pkg::ST_RESET: begin
            if (rst_cnt_r == '0) begin
               st_nxt = uwpc_pkg::ST_STANDBY;
            end
         end
         uwpc_pkg::ST_SLEEP: begin
            if (wtx_q_r && wrx_q_r) begin
               st_nxt = uwpc_pkg::ST_STANDBY;
            end
         end
         uwpc_pkg::ST_STANDBY: begin
            if (TX_REQ_IN && !RX_REQ_IN) begin
               st_nxt = uwpc_pkg::ST_TX;
            end else if (RX_REQ_IN && !TX_REQ_IN) begin
               st_nxt = uwpc_pkg::ST_RX;
            end else if (sleep_q_r && !TX_REQ_IN && !RX_REQ_IN) begin
               st_nxt = uwpc_pkg::ST_SLEEP;
            end
         end
         uwpc_pkg::ST_TX: begin
            if (!TX_REQ_IN) begin
               st_nxt = RX_REQ_IN ? uwpc_pkg::ST_RX : uwpc_pkg::ST_STANDBY;
            end
         end
         uwpc_pkg::ST_RX: begin
            if (!RX_REQ_IN) begin
               st_nxt = TX_REQ_IN ? uwpc_pkg::ST_TX : uwpc_pkg::ST_STANDBY;
            end
         end
         default: begin
            st_nxt = uwpc_pkg::ST_STANDBY;
         end
      endcase
   end

   always_ff @(posedge LINK_CLK_IN or negedge link_rst_n) begin
      if (!link_rst_n) begin
         st_r      <= uwpc_pkg::ST_RESET;
         rst_cnt_r <= RESET_CYC[uwpc_pkg::RST_CNT_W-1:0];
      end else begin
         st_r <= st_nxt;
         if (rst_cnt_r != '0) begin
            rst_cnt_r <= rst_cnt_r - 1'b1;
         end
      end
   end

   assign POWER_MODE_OUT = st_r;
   assign RADIO_ON_OUT   = (st_r == uwpc_pkg::ST_TX) || (st_r == uwpc_pkg::ST_RX);

   ////////////////////////////////////////////////////////////////////////////
   // interface clock: gate flop changes while the source is low

   logic pclk_en_r;

   always_ff @(negedge LINK_CLK_IN or negedge link_rst_n) begin
      if (!link_rst_n) begin
         pclk_en_r <= uwpc_pkg::PCLK_EN_RESET;
      end else begin
         pclk_en_r <= (st_r != uwpc_pkg::ST_SLEEP) &&
                      !((st_r == uwpc_pkg::ST_STANDBY) && stop_q_r);
      end
   end

   assign PCLK_OUT = LINK_CLK_IN & pclk_en_r;

   ////////////////////////////////////////////////////////////////////////////
   // activity, strobe and data bus
   logic cap_arm_r;
   logic cap_pend_r;
   always_ff @(posedge LINK_CLK_IN or negedge link_rst_n) begin
      if (!link_rst_n) begin
         AIR_ACTIVITY_OUT <= 1'b0;
      end else begin
         AIR_ACTIVITY_OUT <= frame_q_r && RADIO_ON_OUT;
      end
   end

   always_ff @(posedge LINK_CLK_IN or negedge link_rst_n) begin
      if (!link_rst_n) begin
         BYTE_STROBE_OUT <= 1'b0;
         DATA_OUT        <= uwpc_pkg::DATA_RESET;
         rx_ack_tgl_r    <= 1'b0;
      end else begin
         BYTE_STROBE_OUT <= (tx_edge && st_r == uwpc_pkg::ST_TX) ||
                            (rx_edge && st_r == uwpc_pkg::ST_RX);
         if (rx_edge) begin
            rx_ack_tgl_r <= ~rx_ack_tgl_r;
            if (st_r == uwpc_pkg::ST_RX) begin
               DATA_OUT <= rx_hold_r;
            end
         end
      end
   end

   // byte is on the bus the cycle after the pull strobe; take it at the end of that cycle
   always_ff @(posedge LINK_CLK_IN or negedge link_rst_n) begin
      if (!link_rst_n) begin
         cap_arm_r    <= 1'b0;
         cap_pend_r   <= 1'b0;
         tx_byte_r    <= uwpc_pkg::DATA_RESET;
         tx_ok_r      <= 1'b0;
         tx_ack_tgl_r <= 1'b0;
      end else begin
         cap_arm_r  <= tx_edge && (st_r == uwpc_pkg::ST_TX);
         cap_pend_r <= cap_arm_r;
         if (cap_pend_r) begin
            tx_byte_r    <= DATA_IN;
            tx_ok_r      <= 1'b1;
            tx_ack_tgl_r <= ~tx_ack_tgl_r;
         end else if (tx_edge && st_r != uwpc_pkg::ST_TX) begin
            tx_ok_r      <= 1'b0;
            tx_ack_tgl_r <= ~tx_ack_tgl_r;
         end
      end
   end

   // released in transmit and for one cycle after leaving it
   always_ff @(posedge LINK_CLK_IN or negedge link_rst_n) begin
      if (!link_rst_n) begin
         DATA_OE_N_OUT <= 1'b0;
      end else begin
         DATA_OE_N_OUT <= (st_nxt == uwpc_pkg::ST_TX) ||
                          (st_r == uwpc_pkg::ST_TX);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_tx_left;
      (st_r == uwpc_pkg::ST_TX) ##1 (st_r != uwpc_pkg::ST_TX);
   endsequence
   sequence s_sleep_held;
      (st_r == uwpc_pkg::ST_SLEEP) [*2];
   endsequence
   chk_enter_tx: assert property (@(posedge LINK_CLK_IN) disable iff (!link_rst_n)
      (st_r == uwpc_pkg::ST_STANDBY && TX_REQ_IN && !RX_REQ_IN) |=> (st_r == uwpc_pkg::ST_TX))
      else $error("transmit request did not enter transmit");
   chk_enter_rx: assert property (@(posedge LINK_CLK_IN) disable iff (!link_rst_n)
      (st_r == uwpc_pkg::ST_STANDBY && RX_REQ_IN && !TX_REQ_IN) |=> (st_r == uwpc_pkg::ST_RX))
      else $error("receive request did not enter receive");
   chk_wake_standby: assert property (@(posedge LINK_CLK_IN) disable iff (!link_rst_n)
      (st_r == uwpc_pkg::ST_SLEEP && wtx_q_r && wrx_q_r) |=> (st_r == uwpc_pkg::ST_STANDBY))
      else $error("wake from sleep missed");
   chk_air_idle: assert property (@(posedge LINK_CLK_IN) disable iff (!link_rst_n)
      (!RADIO_ON_OUT || !frame_q_r) |=> !AIR_ACTIVITY_OUT)
      else $error("activity outside a frame");
   chk_clock_stop: assert property (@(posedge LINK_CLK_IN) disable iff (!link_rst_n)
      (st_r == uwpc_pkg::ST_STANDBY && stop_q_r) ##1 (st_r == uwpc_pkg::ST_STANDBY && stop_q_r)
      |-> !pclk_en_r)
      else $error("clock runs under clock-stop");
   chk_sleep_clock: assert property (@(posedge LINK_CLK_IN) disable iff (!link_rst_n)
      s_sleep_held |-> (!pclk_en_r && !RADIO_ON_OUT))
      else $error("clock or radio on in sleep");
   chk_rx_strobe: assert property (@(posedge LINK_CLK_IN) disable iff (!link_rst_n)
      (rx_edge && st_r == uwpc_pkg::ST_RX) |=> (BYTE_STROBE_OUT && !DATA_OE_N_OUT
                                                && DATA_OUT == $past(rx_hold_r)))
      else $error("receive byte not presented");
   chk_strobe_pulse: assert property (@(posedge LINK_CLK_IN) disable iff (!link_rst_n)
      BYTE_STROBE_OUT |=> !BYTE_STROBE_OUT)
      else $error("strobe longer than one cycle");
   chk_bus_release: assert property (@(posedge LINK_CLK_IN) disable iff (!link_rst_n)
      (st_r == uwpc_pkg::ST_TX) |-> DATA_OE_N_OUT)
      else $error("PHY drives bus in transmit");
   chk_turnaround: assert property (@(posedge LINK_CLK_IN) disable iff (!link_rst_n)
      s_tx_left |-> DATA_OE_N_OUT)
      else $error("no turnaround after transmit");
   chk_reset_standby: assert property (@(posedge LINK_CLK_IN) disable iff (!link_rst_n)
      (st_r == uwpc_pkg::ST_RESET && rst_cnt_r == '0) |=> (st_r == uwpc_pkg::ST_STANDBY))
      else $error("reset did not end in standby");

endmodule

`default_nettype wire

//--- rtl/uwpc_pkg.sv
// constants and types shared by the PHY-side interface controller
package uwpc_pkg;

   // nominal interface clock, in kHz
   localparam int            IF_CLK_KHZ     = 66000;
   // time the PHY spends completing its reset after release, in ns
   localparam int            RESET_DONE_NS  = 200;
   // least time rounds up to whole interface clock cycles
   localparam int            RESET_DONE_CYC = (RESET_DONE_NS * IF_CLK_KHZ + 999999) / 1000000;
   localparam int            RST_CNT_W      = 8;
   localparam logic [7:0]    DATA_RESET     = 8'h00;
   localparam logic          PCLK_EN_RESET  = 1'b1;

   // operating states, one-hot; the code is also the power mode field
   typedef enum logic [4:0] {
      ST_RESET   = 5'h01,
      ST_SLEEP   = 5'h02,
      ST_STANDBY = 5'h04,
      ST_TX      = 5'h08,
      ST_RX      = 5'h10
   } uwpc_state_t;

endpackage

//--- sim/uwpc_mac_model.sv
// MAC-side partner model: state requests, transmit bytes, received bytes
`timescale 1ns/100ps
`default_nettype none

module uwpc_mac_model (
   input  wire logic       pclk_in,    // interface clock from PHY
   input  wire logic [4:0] mode_in,    // PHY power mode field
   input  wire logic       strobe_in,  // byte strobe from PHY
   input  wire logic [7:0] bus_in,     // resolved data bus
   input  wire logic       want_tx_in, // bench asks for transmit
   input  wire logic       want_rx_in, // bench asks for receive
   output logic            tx_req_out, // transmit request
   output logic            rx_req_out, // receive request
   output logic            oe_out,     // high while MAC drives bus
   output logic      [7:0] data_out    // MAC drive value
);
   logic [7:0] tx_q[$];
   logic [7:0] rx_q[$];
   logic       tx_r = 1'b0;
   logic       rx_r = 1'b0;
   logic       sleeping;
   logic [7:0] drv_r = 8'hA5;

   ////////////////////////////////////////////////////////////////////////////
   // clock is stopped in sleep, so requests pass through unclocked there
   assign sleeping   = (mode_in === uwpc_pkg::ST_SLEEP);
   assign tx_req_out = sleeping ? want_tx_in : tx_r;
   assign rx_req_out = sleeping ? want_rx_in : rx_r;
   assign oe_out     = (mode_in === uwpc_pkg::ST_TX) && tx_r;

   ////////////////////////////////////////////////////////////////////////////
   assign data_out = drv_r;
   always @(posedge pclk_in) begin
      tx_r <= want_tx_in;
      rx_r <= want_rx_in;
      // byte stands one cycle after the strobe, then the bus churns
      if (strobe_in && mode_in === uwpc_pkg::ST_TX && tx_q.size() > 0)
         drv_r <= tx_q.pop_front();
      else
         drv_r <= ~drv_r;
      if (strobe_in === 1'b1 && mode_in === uwpc_pkg::ST_RX)
         rx_q.push_back(bus_in);
   end
endmodule
`default_nettype wire

//--- sim/uwpc_phy_if_tb_top.sv
// self-checking testbench for the PHY-side interface controller
`timescale 1ns/100ps
`default_nettype none

module uwpc_phy_if_tb_top;
   logic       clk = 1'b0;
   logic       lclk = 1'b0;
   logic       nrst = 1'b0;
   logic       clk_stop = 1'b0;
   logic       sleep_req = 1'b0;
   logic       ant = 1'b0;
   logic       pull = 1'b0;
   logic       rx_vld = 1'b0;
   logic [7:0] rx_byte = 8'h00;
   logic       want_tx = 1'b0;
   logic       want_rx = 1'b0;
   wire        pclk, air, strobe, oe_n, radio, pull_rdy, tx_vld, rx_rdy;
   wire        tx_req, rx_req, mac_oe;
   wire  [7:0] dout, tx_byte, bus, mac_data;
   wire  [4:0] mode;
   int         n_fail = 0;
   int         tests_run = 0;
   int         cyc = 0;
   int         pclk_n = 0;
   int         k;
   int         n;
   logic [7:0] exp_q[$];

   ////////////////////////////////////////////////////////////////////////////
   initial forever #5 clk = ~clk;
   initial begin
      #7;
      forever #32 lclk = ~lclk;
   end
   assign bus = !oe_n ? dout : (mac_oe ? mac_data : ~mac_data);
   always @(posedge pclk) pclk_n++;
   always @(posedge lclk) begin
      if (oe_n === 1'b0 && mac_oe) begin
         n_fail++;
         $display("CHECK FAILED at %0t: bus contention %h %h", $time, dout, mac_data);
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_fail++;
         complete_run();
      end
   end

   uwpc_phy_if #(.RESET_CYC(2)) dut (
      .CLK_IN(clk), .NRST_IN(nrst), .LINK_CLK_IN(lclk), .PCLK_OUT(pclk),
      .TX_REQ_IN(tx_req), .RX_REQ_IN(rx_req), .CLOCK_STOP_REQ_IN(clk_stop),
      .AIR_ACTIVITY_OUT(air), .BYTE_STROBE_OUT(strobe), .DATA_IN(bus),
      .DATA_OUT(dout), .DATA_OE_N_OUT(oe_n), .POWER_MODE_OUT(mode),
      .RADIO_ON_OUT(radio), .SLEEP_REQ_IN(sleep_req), .ANTENNA_FRAME_IN(ant),
      .TX_PULL_IN(pull), .TX_PULL_READY_OUT(pull_rdy), .TX_BYTE_OUT(tx_byte),
      .TX_BYTE_VALID_OUT(tx_vld), .RX_BYTE_IN(rx_byte),
      .RX_BYTE_VALID_IN(rx_vld), .RX_BYTE_READY_OUT(rx_rdy));

   uwpc_mac_model mac (
      .pclk_in(pclk), .mode_in(mode), .strobe_in(strobe), .bus_in(bus),
      .want_tx_in(want_tx), .want_rx_in(want_rx), .tx_req_out(tx_req),
      .rx_req_out(rx_req), .oe_out(mac_oe), .data_out(mac_data));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic pick(input int s);
      case (s)
         0: pick = air;
         1: pick = oe_n;
         default: pick = radio;
      endcase
   endfunction

   task automatic wait_flag(input int s, input logic v);
      int i;
      for (i = 0; i < 60 && pick(s) !== v; i++) @(posedge clk);
      chk(8'(pick(s)), 8'(v));
   endtask

   task automatic wait_mode(input logic [4:0] m);
      int i;
      for (i = 0; i < 400 && mode !== m; i++) @(posedge clk);
      chk(8'(mode), 8'(m));
   endtask

   task automatic tx_one(input logic [7:0] b);
      int i;
      mac.tx_q.push_back(b);
      exp_q.push_back(b);
      for (i = 0; i < 60 && !pull_rdy; i++) @(posedge clk);
      pull <= 1'b1;
      @(posedge clk);
      pull <= 1'b0;
      for (i = 0; i < 100 && tx_vld !== 1'b1; i++) @(posedge clk);
      chk(tx_byte, exp_q.pop_front());
   endtask

   task automatic rx_one(input logic [7:0] b);
      int i;
      for (i = 0; i < 60 && !rx_rdy; i++) @(posedge clk);
      rx_byte <= b;
      rx_vld <= 1'b1;
      @(posedge clk);
      rx_vld <= 1'b0;
      exp_q.push_back(b);
      for (i = 0; i < 100 && mac.rx_q.size() < exp_q.size(); i++) @(posedge clk);
      chk(mac.rx_q.size() > 0 ? mac.rx_q.pop_front() : 8'h00, exp_q.pop_front());
   endtask

   task automatic pclk_idle(input logic stopped);
      n = pclk_n;
      repeat (40) @(posedge clk);
      chk(8'(pclk_n != n), 8'(!stopped));
   endtask

   task automatic complete_run;
      $display("checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h5AF6));
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      chk(8'(mode), 8'(uwpc_pkg::ST_RESET));
      wait_mode(uwpc_pkg::ST_STANDBY);
      chk(8'(oe_n), 8'h00);
      $display("test reset done");

      want_tx <= 1'b1;
      wait_mode(uwpc_pkg::ST_TX);
      chk(8'(oe_n), 8'h01);
      wait_flag(2, 1'b1);
      ant <= 1'b1;
      wait_flag(0, 1'b1);
      for (k = 0; k < 4; k++) tx_one(8'($urandom));
      ant <= 1'b0;
      wait_flag(0, 1'b0);
      want_tx <= 1'b0;
      wait_mode(uwpc_pkg::ST_STANDBY);
      wait_flag(1, 1'b0);
      $display("test transmit done");

      want_tx <= 1'b1;
      want_rx <= 1'b1;
      repeat (30) @(posedge clk);
      chk(8'(mode), 8'(uwpc_pkg::ST_STANDBY));
      want_tx <= 1'b0;
      want_rx <= 1'b0;
      $display("test both requests done");

      want_rx <= 1'b1;
      wait_mode(uwpc_pkg::ST_RX);
      chk(8'(oe_n), 8'h00);
      ant <= 1'b1;
      wait_flag(0, 1'b1);
      for (k = 0; k < 4; k++) rx_one(8'($urandom));
      ant <= 1'b0;
      wait_flag(0, 1'b0);
      want_rx <= 1'b0;
      wait_mode(uwpc_pkg::ST_STANDBY);
      $display("test receive done");

      clk_stop <= 1'b1;
      repeat (20) @(posedge clk);
      pclk_idle(1'b1);
      clk_stop <= 1'b0;
      repeat (20) @(posedge clk);
      pclk_idle(1'b0);
      $display("test clock stop done");

      sleep_req <= 1'b1;
      wait_mode(uwpc_pkg::ST_SLEEP);
      sleep_req <= 1'b0;
      wait_flag(2, 1'b0);
      repeat (10) @(posedge clk);
      pclk_idle(1'b1);
      chk(8'(oe_n), 8'h00);
      want_tx <= 1'b1;
      want_rx <= 1'b1;
      wait_mode(uwpc_pkg::ST_STANDBY);
      want_tx <= 1'b0;
      want_rx <= 1'b0;
      pclk_idle(1'b0);
      $display("test sleep done");
      complete_run();
   end
endmodule
`default_nettype wire
